// file: hdl/adc_ref_and_monitor_select.sv
// Functional notes
// - Bit 7 reads back the clock source (0 internal, 1 external) and ignores writes.
// - Reference power code 00 (default) keeps the internal reference off, 01 keeps it on.
// - Codes 10 and 11 power the reference during conversions and drop it on sleep or start low.
// - Bits 4-3 pick external pair 0, pair 1, internal, or internal driven onto pair-0 pins.
// - A nonzero monitor code overrides the input source, bias and pair-0 reference drive; the reference select is kept.
// - Monitor 000 is normal, 001 ties inputs to mid-supply, 010 routes the reference.
// - Monitor 011 routes the temperature diode, 100 pair-1 ref/4, 101 pair-0 ref/4.
// - Monitor 110 routes analog supply/4, 111 digital supply/4, inputs disconnected.
// - Monitor codes 010 to 111 force unity gain; 000 and 001 use the stored gain.
// - Returning to normal or offset mode reapplies the stored gain.
`timescale 1ns/100ps
`default_nettype none
module adc_ref_and_monitor_select
	import refmon_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ext_clk_sel,
	input wire logic start_pin,
	input wire logic conv_busy,
	input wire logic sleep_cmd,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output refmon_pkg::analog_ctl_s analog_ctl
);
	import refmon_pkg::*;

	logic clk_meta_r, clk_src_r;
	logic start_meta_r, start_sync_r;
	logic [6:0] ref_mon_r;
	logic [7:0] sys_ctl_r;
	logic [7:0] in_sel_r;
	logic [7:0] bias_r;
	logic sleep_r;
	logic busy_prev_r;
	logic busy_rise;
	logic ref_on_r;
	logic [7:0] awaddr_r;
	logic aw_held_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic w_held_r;
	logic wr_go;
	logic wr_hit;
	ref_pwr_e ref_pwr;
	mon_sel_e mon;
	analog_ctl_s ctl_nxt;

	// Both pins come from outside mclk
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_meta_r <= 1'b0;
			clk_src_r <= 1'b0;
			start_meta_r <= 1'b0;
			start_sync_r <= 1'b0;
		end
		else
		begin
			clk_meta_r <= ext_clk_sel;
			clk_src_r <= clk_meta_r;
			start_meta_r <= start_pin;
			start_sync_r <= start_meta_r;
		end
	end

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == ADDR_REF_MON) || (a == ADDR_SYS_CTL) || (a == ADDR_IN_SEL) ||
			(a == ADDR_BIAS) || (a == ADDR_STATUS) || (a == ADDR_CONTROL);
	endfunction

	// Write channel: address and data taken independently, in either order
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign wr_go = aw_held_r && w_held_r;
	assign wr_hit = wr_go && wstrb_r[0];

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_r <= 1'b0;
			awaddr_r <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end
		else if (wr_go)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			w_held_r <= 1'b0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end
		else if (wr_go)
			w_held_r <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Bit 7 has no storage; writes to it fall away
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ref_mon_r <= REF_MON_RST;
		else if (wr_hit && awaddr_r == ADDR_REF_MON)
			ref_mon_r <= wdata_r[6:0];
	end

	// Stored settings are written only by software, never by the override
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sys_ctl_r <= SYS_CTL_RST;
			in_sel_r <= IN_SEL_RST;
			bias_r <= BIAS_RST;
		end
		else if (wr_hit)
		begin
			if (awaddr_r == ADDR_SYS_CTL)
				sys_ctl_r <= {1'b0, wdata_r[6:0]};
			if (awaddr_r == ADDR_IN_SEL)
				in_sel_r <= wdata_r[7:0];
			if (awaddr_r == ADDR_BIAS)
				bias_r <= wdata_r[7:0];
		end
	end

	// Start edge only, so a busy level held high cannot undo a sleep
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			busy_prev_r <= 1'b0;
		else
			busy_prev_r <= conv_busy;
	end

	assign busy_rise = conv_busy && !busy_prev_r;

	// Sleep request latches until a conversion starts again; a set beats the clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			sleep_r <= 1'b0;
		else if (sleep_cmd || (wr_hit && awaddr_r == ADDR_CONTROL && wdata_r[0]))
			sleep_r <= 1'b1;
		else if (busy_rise)
			sleep_r <= 1'b0;
	end

	assign ref_pwr = ref_pwr_e'(ref_mon_r[REF_PWR_LSB +: 2]);
	assign mon = mon_sel_e'(ref_mon_r[MON_LSB +: 3]);

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ref_on_r <= 1'b0;
		else
		begin
			unique case (ref_pwr)
				REFPWR_OFF: ref_on_r <= 1'b0;
				REFPWR_ON: ref_on_r <= 1'b1;
				REFPWR_CONV_A, REFPWR_CONV_B:
					ref_on_r <= conv_busy && start_sync_r && !sleep_r && !sleep_cmd;
			endcase
		end
	end

	always_comb
	begin
		ctl_nxt.pos_sel = in_sel_r[POS_LSB +: 3];
		ctl_nxt.neg_sel = in_sel_r[2:0];
		ctl_nxt.bias_en = bias_r;
		ctl_nxt.ref_sel = ref_sel_e'(ref_mon_r[REF_SEL_LSB +: 2]);
		ctl_nxt.ref_drive_pair0 = (ctl_nxt.ref_sel == REFSEL_INT_DRIVE0);
		ctl_nxt.gain = sys_ctl_r[GAIN_LSB +: 3];
		ctl_nxt.ref_power = ref_on_r;
		ctl_nxt.src = SRC_PINS;
		unique case (mon)
			MON_NORMAL: ctl_nxt.src = SRC_PINS;
			MON_OFFSET: ctl_nxt.src = SRC_MIDSUPPLY;
			MON_GAIN: ctl_nxt.src = SRC_VREF;
			MON_TEMP: ctl_nxt.src = SRC_TEMP_DIODE;
			MON_REF1: ctl_nxt.src = SRC_REF1_DIV4;
			MON_REF0: ctl_nxt.src = SRC_REF0_DIV4;
			MON_AVDD: ctl_nxt.src = SRC_AVDD_DIV4;
			MON_DVDD: ctl_nxt.src = SRC_DVDD_DIV4;
		endcase
		// Override leaves no pin switch closed; stored fields stay untouched
		if (mon != MON_NORMAL)
		begin
			ctl_nxt.bias_en = 8'h00;
			ctl_nxt.ref_drive_pair0 = 1'b0;
		end
		if (mon != MON_NORMAL && mon != MON_OFFSET)
			ctl_nxt.gain = GAIN_UNITY;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			analog_ctl <= '0;
		else
			analog_ctl <= ctl_nxt;
	end

	// Read channel: one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			s_axi_rdata <= 32'h00000000;
			unique case (s_axi_araddr)
				ADDR_REF_MON: s_axi_rdata <= {24'h000000, clk_src_r, ref_mon_r};
				ADDR_SYS_CTL: s_axi_rdata <= {24'h000000, sys_ctl_r};
				ADDR_IN_SEL: s_axi_rdata <= {24'h000000, in_sel_r};
				ADDR_BIAS: s_axi_rdata <= {24'h000000, bias_r};
				ADDR_STATUS: s_axi_rdata <= {24'h000000, 3'h0, analog_ctl.src, sleep_r, ref_on_r};
				ADDR_CONTROL: s_axi_rdata <= 32'h00000000;
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	a_unity_gain: assert property (@(posedge mclk) disable iff (!rst_n)
		(mon != MON_NORMAL && mon != MON_OFFSET) |=> analog_ctl.gain == GAIN_UNITY)
		else $error("gain not forced to one in monitor mode");

	a_stored_gain: assert property (@(posedge mclk) disable iff (!rst_n)
		(mon == MON_NORMAL || mon == MON_OFFSET) |=> analog_ctl.gain == $past(sys_ctl_r[6:4]))
		else $error("stored gain not applied");

	a_bias_override: assert property (@(posedge mclk) disable iff (!rst_n)
		(mon != MON_NORMAL) |=> analog_ctl.bias_en == 8'h00)
		else $error("bias enabled under monitor override");

	a_ref_off: assert property (@(posedge mclk) disable iff (!rst_n)
		(ref_pwr == REFPWR_OFF) |=> !ref_on_r)
		else $error("reference on in off mode");

	a_ref_always_on: assert property (@(posedge mclk) disable iff (!rst_n)
		(ref_pwr == REFPWR_ON) |=> ref_on_r)
		else $error("reference off in always-on mode");

	a_ref_sleep_down: assert property (@(posedge mclk) disable iff (!rst_n)
		(ref_pwr[1] && (sleep_cmd || !start_sync_r)) |=> !ref_on_r)
		else $error("reference not powered down");

	a_src_decode: assert property (@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> analog_ctl.src == adc_src_e'($past(ref_mon_r[2:0])))
		else $error("monitor source decode wrong");

	a_drive_pair0: assert property (@(posedge mclk) disable iff (!rst_n)
		(mon == MON_NORMAL && ref_mon_r[4:3] == 2'h3) |=> analog_ctl.ref_drive_pair0)
		else $error("internal reference not driven to pair 0");

	a_clk_flag_ro: assert property (@(posedge mclk) disable iff (!rst_n)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_REF_MON) |=> s_axi_rdata[7] == clk_src_r
		|| s_axi_rdata[7] == $past(clk_src_r))
		else $error("clock flag misreported");

	a_stored_kept: assert property (@(posedge mclk) disable iff (!rst_n)
		(!wr_hit) |=> $stable(in_sel_r) && $stable(bias_r) && $stable(sys_ctl_r))
		else $error("stored settings changed without write");

	sequence s_sleep_req;
		sleep_cmd || (wr_hit && awaddr_r == ADDR_CONTROL && wdata_r[0]);
	endsequence

	sequence s_mon_exit;
		(mon != MON_NORMAL && mon != MON_OFFSET) ##1 (mon == MON_NORMAL || mon == MON_OFFSET);
	endsequence

	a_sleep_set: assert property (@(posedge mclk) disable iff (!rst_n)
		s_sleep_req |=> sleep_r)
		else $error("sleep request lost");

	a_sleep_ref_down: assert property (@(posedge mclk) disable iff (!rst_n)
		(ref_pwr[1] && sleep_r) |=> !ref_on_r)
		else $error("reference on while asleep");

	a_gain_restore: assert property (@(posedge mclk) disable iff (!rst_n)
		s_mon_exit |=> analog_ctl.gain == $past(sys_ctl_r[6:4]))
		else $error("stored gain not restored after monitor");

	a_ref_sel_kept: assert property (@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> analog_ctl.ref_sel == ref_sel_e'($past(ref_mon_r[4:3])))
		else $error("stored reference select lost");

	a_pins_kept: assert property (@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> {analog_ctl.pos_sel, analog_ctl.neg_sel} == $past(in_sel_r[5:0]))
		else $error("stored input select lost");
endmodule
`default_nettype wire

// file: common/refmon_pkg.sv
`default_nettype none
package refmon_pkg;
	// Register byte addresses (AXI4-Lite, one aligned word each)
	localparam logic [7:0] ADDR_REF_MON = 8'h08;
	localparam logic [7:0] ADDR_SYS_CTL = 8'h0C;
	localparam logic [7:0] ADDR_IN_SEL = 8'h00;
	localparam logic [7:0] ADDR_BIAS = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_CONTROL = 8'h14;

	// Field positions in reference_and_monitor_control, system control (gain) and input select (positive input)
	localparam int CLK_SRC_BIT = 7;
	localparam int REF_PWR_LSB = 5;
	localparam int REF_SEL_LSB = 3;
	localparam int MON_LSB = 0;
	localparam int GAIN_LSB = 4;
	localparam int POS_LSB = 3;

	// Reset values
	localparam logic [6:0] REF_MON_RST = 7'h00;
	localparam logic [7:0] SYS_CTL_RST = 8'h00;
	localparam logic [7:0] IN_SEL_RST = 8'h01;
	localparam logic [7:0] BIAS_RST = 8'h00;

	localparam logic [2:0] GAIN_UNITY = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {REFPWR_OFF, REFPWR_ON, REFPWR_CONV_A, REFPWR_CONV_B} ref_pwr_e;
	typedef enum logic [1:0] {REFSEL_EXT0, REFSEL_EXT1, REFSEL_INT, REFSEL_INT_DRIVE0} ref_sel_e;
	typedef enum logic [2:0] {
		MON_NORMAL, MON_OFFSET, MON_GAIN, MON_TEMP, MON_REF1, MON_REF0, MON_AVDD, MON_DVDD
	} mon_sel_e;

	// Source routed to the converter inputs
	typedef enum logic [2:0] {
		SRC_PINS, SRC_MIDSUPPLY, SRC_VREF, SRC_TEMP_DIODE, SRC_REF1_DIV4, SRC_REF0_DIV4,
		SRC_AVDD_DIV4, SRC_DVDD_DIV4
	} adc_src_e;

	typedef struct packed {
		adc_src_e src;
		logic [2:0] pos_sel;
		logic [2:0] neg_sel;
		logic [7:0] bias_en;
		ref_sel_e ref_sel;
		logic ref_drive_pair0;
		logic [2:0] gain;
		logic ref_power;
	} analog_ctl_s;
endpackage
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire logic mclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] st, output logic [1:0] resp);
		logic a_done;
		logic w_done;
		a_done = 1'b0;
		w_done = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dat;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(a_done && w_done))
		begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready)
			begin
				a_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (!s_axi_rvalid);
		dat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: tb/adc_ref_and_monitor_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module adc_ref_and_monitor_select_tb_top;
	import refmon_pkg::*;
	logic mclk, rst_n, ext_clk_sel, start_pin, conv_busy, sleep_cmd;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	analog_ctl_s analog_ctl;
	int miscompares = 0;
	int n_tests = 0;
	int code;
	adc_ref_and_monitor_select u_dut (
		.mclk(mclk), .rst_n(rst_n), .ext_clk_sel(ext_clk_sel), .start_pin(start_pin),
		.conv_busy(conv_busy), .sleep_cmd(sleep_cmd),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_ctl(analog_ctl)
	);
	host_model u_host (
		.mclk(mclk),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
	);
	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		u_host.rd(a, d, r);
		cmp(d, e);
		cmp(32'(r), 32'(er));
	endtask
	task automatic wr8(input logic [7:0] a, input logic [7:0] v);
		u_host.wr(a, {24'h0, v}, 4'hF, r);
		cmp(32'(r), 32'(RESP_OKAY));
		// Register, then reference flop, then output flop: let all settle
		repeat (2) @(posedge mclk);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	initial
	begin
		#400000;
		miscompares++;
		final_report();
	end
	initial
	begin
		{rst_n, ext_clk_sel, start_pin, conv_busy, sleep_cmd} = '0;
		cyc(20);
		rst_n <= 1'b1;
		rd_chk(ADDR_REF_MON, 32'h0, RESP_OKAY);
		rd_chk(ADDR_IN_SEL, 32'h1, RESP_OKAY);
		rd_chk(8'h1C, 32'h0, RESP_SLVERR);
		ext_clk_sel <= 1'b1;
		cyc(4);
		wr8(ADDR_REF_MON, 8'h00);
		rd_chk(ADDR_REF_MON, 32'h80, RESP_OKAY);
		u_host.wr(ADDR_REF_MON, 32'h1F, 4'h0, r);
		cmp(32'(r), 32'(RESP_OKAY));
		rd_chk(ADDR_REF_MON, 32'h80, RESP_OKAY);
		ext_clk_sel <= 1'b0;
		cyc(4);
		wr8(ADDR_REF_MON, 8'h80);
		rd_chk(ADDR_REF_MON, 32'h0, RESP_OKAY);
		for (int i = 0; i < 4; i++)
		begin
			wr8(ADDR_REF_MON, {3'b001, 2'(i), 3'b000});
			cmp(32'(analog_ctl.ref_sel), 32'(i));
			cmp(32'(analog_ctl.ref_drive_pair0), 32'(i == 3));
		end
		wr8(ADDR_SYS_CTL, 8'hD0);
		wr8(ADDR_BIAS, 8'hA5);
		wr8(ADDR_IN_SEL, 8'h2A);
		// Descending order so 2 to 1 restores gain and 1 to 0 keeps the stored gain
		for (int k = 0; k < 9; k++)
		begin
			code = (8 - k) % 8;
			wr8(ADDR_REF_MON, {3'b001, 2'b01, 3'(code)});
			cmp(32'(analog_ctl.src), 32'(code));
			cmp(32'(analog_ctl.gain), (code < 2) ? 32'h5 : 32'h0);
			cmp(32'(analog_ctl.bias_en), (code == 0) ? 32'hA5 : 32'h0);
			cmp(32'({analog_ctl.pos_sel, analog_ctl.neg_sel, analog_ctl.ref_sel}), 32'hA9);
		end
		rd_chk(ADDR_SYS_CTL, 32'h50, RESP_OKAY);
		wr8(ADDR_REF_MON, 8'h00);
		cmp(32'(analog_ctl.ref_power), 32'h0);
		wr8(ADDR_REF_MON, 8'h20);
		cmp(32'(analog_ctl.ref_power), 32'h1);
		for (int c = 2; c < 4; c++)
		begin
			start_pin <= 1'b1;
			conv_busy <= 1'b1;
			wr8(ADDR_REF_MON, {1'b0, 2'(c), 5'h00});
			cyc(6);
			cmp(32'(analog_ctl.ref_power), 32'h1);
			start_pin <= 1'b0;
			cyc(6);
			cmp(32'(analog_ctl.ref_power), 32'h0);
			start_pin <= 1'b1;
			cyc(6);
			cmp(32'(analog_ctl.ref_power), 32'h1);
			sleep_cmd <= 1'b1;
			cyc(1);
			sleep_cmd <= 1'b0;
			cyc(4);
			cmp(32'(analog_ctl.ref_power), 32'h0);
			conv_busy <= 1'b0;
			cyc(4);
			cmp(32'(analog_ctl.ref_power), 32'h0);
		end
		conv_busy <= 1'b1;
		cyc(6);
		rd_chk(ADDR_STATUS, 32'h01, RESP_OKAY);
		wr8(ADDR_CONTROL, 8'h01);
		rd_chk(ADDR_STATUS, 32'h02, RESP_OKAY);
		rd_chk(ADDR_CONTROL, 32'h0, RESP_OKAY);
		wr8(ADDR_REF_MON, 8'h63);
		rd_chk(ADDR_STATUS, 32'h0E, RESP_OKAY);
		final_report();
	end
endmodule
`default_nettype wire
